// *** rtl/csc_pkg.sv ***
// Package for the charge state controller: register map, fields and constants
package csc_pkg;

  // Charge states, one-hot
  typedef enum logic [1:0] {
    CSC_TRICKLE = 2'h1,
    CSC_FAST    = 2'h2
  } csc_state_e;

  // Register byte offsets
  localparam logic [3:0] CSC_OFS_STATUS  = 4'h0;
  localparam logic [3:0] CSC_OFS_MASK    = 4'h4;
  localparam logic [3:0] CSC_OFS_STATE   = 4'h8;
  localparam logic [3:0] CSC_OFS_CONTROL = 4'hC;

  // Event bit positions in status and mask
  localparam int CSC_EV_FAST    = 0;
  localparam int CSC_EV_TRICKLE = 1;
  localparam int CSC_EV_TIMEOUT = 2;
  localparam int CSC_EV_SLOPE   = 3;
  localparam int CSC_EV_HOT     = 4;
  localparam int CSC_EV_WIDTH   = 5;

  // State register fields
  localparam int CSC_ST_FAST    = 0;
  localparam int CSC_ST_HOTLOCK = 1;
  localparam int CSC_ST_WARMUSE = 2;

  // Control register fields
  localparam int CSC_CTL_ENABLE = 0;

  // Reset values
  localparam logic [CSC_EV_WIDTH-1:0] CSC_MASK_RST = 5'h00;
  localparam logic                    CSC_ENABLE_RST = 1'h1;

  // AXI responses
  localparam logic [1:0] CSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CSC_RESP_SLVERR = 2'h2;

endpackage

// *** rtl/csc_charge_state_controller.sv ***
// Two-state fast/trickle charge controller with AXI4-Lite registers
// Functional notes
// - Only two states exist, fast or trickle, nothing else.
// - Supply-settle reset low forces and holds trickle; rising permits fast.
// - Timeout or voltage-slope event forces trickle regardless of other inputs.
// - At power-up with current flowing, good temperature and voltage, go fast.
// - Battery insertion with good temperature and voltage enters fast charge.
// - Cold at power-up: first warm-enough rising edge starts fast charge.
// - Later warm-enough rising edges leave the charge state unchanged.
// - Too hot at start blocks fast charge until supply-settle reset cycles.
// - Fast charge holds until temperature, timeout or slope termination fires, or undervoltage or regulation appears.
// - Undervoltage flag present blocks fast charge start.
// - Hot limit crossing ends fast charge; no restart after cooling.
module csc_charge_state_controller (
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic        SUPPLY_SETTLED,
  input  wire logic        CELL_UNDERVOLT,
  input  wire logic        IN_REGULATION,
  input  wire logic        WARM_ENOUGH,
  input  wire logic        NOT_OVERHEATED,
  input  wire logic        CHARGE_TIMEOUT,
  input  wire logic        SLOPE_DETECT,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             FAST_CHARGE,
  output logic             IRQ
);

  localparam int EW = csc_pkg::CSC_EV_WIDTH;

  csc_pkg::csc_state_e state_reg;
  csc_pkg::csc_state_e state_next;
  logic          settle_q;
  logic          warm_q;
  logic          noth_q;
  logic          uv_q;
  logic          reg_q;
  logic          hot_lock_reg;
  logic          warm_used_reg;
  logic          enable_reg;
  logic [EW-1:0] status_reg;
  logic [EW-1:0] mask_reg;
  logic [EW-1:0] event_now;
  logic          aw_held;
  logic          w_held;
  logic [3:0]    aw_addr_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;
  logic          status_rd;
  logic          warm_rise;
  logic          noth_fall;
  logic          uv_fall;
  logic          reg_fall;
  logic          settle_rise;
  logic          terminate;
  logic          start_ok;
  logic          wr_fire;

  // Previous levels for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      settle_q <= 1'b0;
      warm_q   <= 1'b1; // Idle warm level, no false edge after reset
      noth_q   <= 1'b0;
      uv_q     <= 1'b0;
      reg_q    <= 1'b0;
    end else begin
      settle_q <= SUPPLY_SETTLED;
      warm_q   <= WARM_ENOUGH;
      noth_q   <= NOT_OVERHEATED;
      uv_q     <= CELL_UNDERVOLT;
      reg_q    <= IN_REGULATION;
    end
  end

  // Edge terms
  assign settle_rise = SUPPLY_SETTLED & ~settle_q;
  assign warm_rise   = WARM_ENOUGH & ~warm_q;
  assign noth_fall   = ~NOT_OVERHEATED & noth_q;
  assign uv_fall     = ~CELL_UNDERVOLT & uv_q;
  assign reg_fall    = ~IN_REGULATION & reg_q;

  // Termination and start qualification
  assign terminate = CHARGE_TIMEOUT | SLOPE_DETECT | noth_fall | ~NOT_OVERHEATED;
  assign start_ok  = enable_reg & ~CELL_UNDERVOLT & ~IN_REGULATION & WARM_ENOUGH
                   & NOT_OVERHEATED & ~hot_lock_reg;

  // Hot lockout: too hot at start, or overheat during any phase, latches until settle cycles
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      hot_lock_reg <= 1'b0;
    end else if (!SUPPLY_SETTLED) begin
      hot_lock_reg <= 1'b0;
    end else if (!NOT_OVERHEATED) begin
      hot_lock_reg <= 1'b1;
    end
  end

  // Warm-enough edge is used once per settle cycle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      warm_used_reg <= 1'b0;
    end else if (!SUPPLY_SETTLED) begin
      warm_used_reg <= 1'b0;
    end else if (warm_rise) begin
      warm_used_reg <= 1'b1;
    end
  end

  // Next charge state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      csc_pkg::CSC_TRICKLE: begin
        if (SUPPLY_SETTLED && !CHARGE_TIMEOUT && !SLOPE_DETECT && start_ok &&
            (settle_rise || uv_fall || reg_fall || (warm_rise && !warm_used_reg))) begin
          state_next = csc_pkg::CSC_FAST;
        end
      end
      csc_pkg::CSC_FAST: begin
        if (terminate || CELL_UNDERVOLT || IN_REGULATION) begin
          state_next = csc_pkg::CSC_TRICKLE;
        end
      end
      default: state_next = csc_pkg::CSC_TRICKLE;
    endcase
    if (!SUPPLY_SETTLED) begin
      state_next = csc_pkg::CSC_TRICKLE;
    end
  end

  // Charge state register
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_reg <= csc_pkg::CSC_TRICKLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Output flag
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      FAST_CHARGE <= 1'b0;
    end else begin
      FAST_CHARGE <= (state_next == csc_pkg::CSC_FAST);
    end
  end

  // Events for the sticky status
  always_comb begin
    event_now = '0;
    event_now[csc_pkg::CSC_EV_FAST]    = (state_reg == csc_pkg::CSC_TRICKLE) && (state_next == csc_pkg::CSC_FAST);
    event_now[csc_pkg::CSC_EV_TRICKLE] = (state_reg == csc_pkg::CSC_FAST) && (state_next == csc_pkg::CSC_TRICKLE);
    event_now[csc_pkg::CSC_EV_TIMEOUT] = CHARGE_TIMEOUT && (state_reg == csc_pkg::CSC_FAST);
    event_now[csc_pkg::CSC_EV_SLOPE]   = SLOPE_DETECT && (state_reg == csc_pkg::CSC_FAST);
    event_now[csc_pkg::CSC_EV_HOT]     = noth_fall;
  end

  // Sticky status: read clears, set wins
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_rd ? '0 : status_reg) | event_now;
    end
  end

  // Interrupt level
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((status_rd ? '0 : status_reg) | event_now) & mask_reg);
    end
  end

  // Write channel capture
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= csc_pkg::CSC_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held     <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_reg == csc_pkg::CSC_OFS_MASK || aw_addr_reg == csc_pkg::CSC_OFS_CONTROL ||
                         aw_addr_reg == csc_pkg::CSC_OFS_STATUS || aw_addr_reg == csc_pkg::CSC_OFS_STATE)
                        ? csc_pkg::CSC_RESP_OKAY : csc_pkg::CSC_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Writable registers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      mask_reg   <= csc_pkg::CSC_MASK_RST;
      enable_reg <= csc_pkg::CSC_ENABLE_RST;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == csc_pkg::CSC_OFS_MASK) begin
        mask_reg <= w_data_reg[EW-1:0];
      end
      if (aw_addr_reg == csc_pkg::CSC_OFS_CONTROL) begin
        enable_reg <= w_data_reg[csc_pkg::CSC_CTL_ENABLE];
      end
    end
  end

  // Read channel
  assign status_rd = S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == csc_pkg::CSC_OFS_STATUS);

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= csc_pkg::CSC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= csc_pkg::CSC_RESP_OKAY;
        S_AXI_RDATA  <= 32'h0;
        case (S_AXI_ARADDR)
          csc_pkg::CSC_OFS_STATUS:  S_AXI_RDATA[EW-1:0] <= status_reg;
          csc_pkg::CSC_OFS_MASK:    S_AXI_RDATA[EW-1:0] <= mask_reg;
          csc_pkg::CSC_OFS_STATE: begin
            S_AXI_RDATA[csc_pkg::CSC_ST_FAST]    <= (state_reg == csc_pkg::CSC_FAST);
            S_AXI_RDATA[csc_pkg::CSC_ST_HOTLOCK] <= hot_lock_reg;
            S_AXI_RDATA[csc_pkg::CSC_ST_WARMUSE] <= warm_used_reg;
          end
          csc_pkg::CSC_OFS_CONTROL: S_AXI_RDATA[csc_pkg::CSC_CTL_ENABLE] <= enable_reg;
          default:                  S_AXI_RRESP <= csc_pkg::CSC_RESP_SLVERR;
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Checks
  property p_settle_low;
    @(posedge SYS_CLK) disable iff (SRST) !SUPPLY_SETTLED |=> !FAST_CHARGE;
  endproperty
  a_settle_low: assert property (p_settle_low) else $error("fast while supply unsettled");

  property p_term;
    @(posedge SYS_CLK) disable iff (SRST) (CHARGE_TIMEOUT || SLOPE_DETECT) |=> !FAST_CHARGE;
  endproperty
  a_term: assert property (p_term) else $error("termination ignored");

  property p_onehot;
    @(posedge SYS_CLK) disable iff (SRST) $onehot(state_reg) && (FAST_CHARGE == (state_reg == csc_pkg::CSC_FAST));
  endproperty
  a_onehot: assert property (p_onehot) else $error("bad state");

  property p_no_start_cold;
    @(posedge SYS_CLK) disable iff (SRST) (!FAST_CHARGE && (!WARM_ENOUGH || !NOT_OVERHEATED)) |=> !FAST_CHARGE;
  endproperty
  a_no_start_cold: assert property (p_no_start_cold) else $error("start while temperature bad");

  property p_hot_lock;
    @(posedge SYS_CLK) disable iff (SRST) (hot_lock_reg && SUPPLY_SETTLED) |=> !FAST_CHARGE;
  endproperty
  a_hot_lock: assert property (p_hot_lock) else $error("fast after overheat");

  property p_uv;
    @(posedge SYS_CLK) disable iff (SRST) (CELL_UNDERVOLT || IN_REGULATION) |=> !FAST_CHARGE;
  endproperty
  a_uv: assert property (p_uv) else $error("fast under lockout or regulation");

  property p_warm_once;
    @(posedge SYS_CLK) disable iff (SRST) (!FAST_CHARGE && warm_used_reg && warm_rise && !settle_rise && !uv_fall
                                           && !reg_fall) |=> !FAST_CHARGE;
  endproperty
  a_warm_once: assert property (p_warm_once) else $error("second warm edge started fast");

  property p_warm_first;
    @(posedge SYS_CLK) disable iff (SRST) (!FAST_CHARGE && SUPPLY_SETTLED && warm_rise && !warm_used_reg && start_ok
                                           && !CHARGE_TIMEOUT && !SLOPE_DETECT) |=> FAST_CHARGE;
  endproperty
  a_warm_first: assert property (p_warm_first) else $error("first warm edge missed");

  property p_power_up;
    @(posedge SYS_CLK) disable iff (SRST) (!FAST_CHARGE && settle_rise && start_ok && !CHARGE_TIMEOUT && !SLOPE_DETECT)
                                          |=> FAST_CHARGE;
  endproperty
  a_power_up: assert property (p_power_up) else $error("power-up start missed");

  property p_hold;
    @(posedge SYS_CLK) disable iff (SRST) (FAST_CHARGE && SUPPLY_SETTLED && !CHARGE_TIMEOUT && !SLOPE_DETECT
                                           && NOT_OVERHEATED && !CELL_UNDERVOLT && !IN_REGULATION) |=> FAST_CHARGE;
  endproperty
  a_hold: assert property (p_hold) else $error("fast dropped without cause");

  property p_insert;
    @(posedge SYS_CLK) disable iff (SRST) (!FAST_CHARGE && SUPPLY_SETTLED && (uv_fall || reg_fall) && start_ok
                                           && !CHARGE_TIMEOUT && !SLOPE_DETECT) |=> FAST_CHARGE;
  endproperty
  a_insert: assert property (p_insert) else $error("insertion start missed");

  property p_timeout_flag;
    @(posedge SYS_CLK) disable iff (SRST) (CHARGE_TIMEOUT && FAST_CHARGE) |=> status_reg[csc_pkg::CSC_EV_TIMEOUT];
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("timeout event not latched");

endmodule

// *** verif/csc_batt_model.sv ***
// Battery, thermistor and regulation loop stand-in driving the condition levels
module csc_batt_model (
  input  wire logic SYS_CLK,
  output logic      settled,
  output logic      undervolt,
  output logic      in_reg,
  output logic      warm,
  output logic      not_hot,
  output logic      timeout,
  output logic      slope
);
  timeunit 1ns;
  timeprecision 1ps;

  // Unpowered, no battery current, before the first edge
  initial begin
    settled   = 1'b0;
    undervolt = 1'b0;
    in_reg    = 1'b1;
    warm      = 1'b1;
    not_hot   = 1'b1;
    timeout   = 1'b0;
    slope     = 1'b0;
  end

  // New condition levels, applied on the calling edge
  task automatic set_env(input logic s, input logic u, input logic r, input logic w, input logic h);
    settled   <= s;
    undervolt <= u;
    in_reg    <= r;
    warm      <= w;
    not_hot   <= h;
  endtask

  // One-cycle termination events
  task automatic fire(input logic t, input logic v);
    timeout <= t;
    slope   <= v;
    @(posedge SYS_CLK);
    timeout <= 1'b0;
    slope   <= 1'b0;
  endtask
endmodule

// *** verif/csc_charge_state_controller_tb.sv ***
// Self-checking bench for the charge state controller
module csc_charge_state_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        srst;
  logic        st, uv, rg, wm, nh, tmo, slp;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rdat, v;
  logic        awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry, fast, irq;
  logic [1:0]  br, rr;
  int          n_errors = 0;
  int          checks = 0;
  logic [1:0]  exp_resp = csc_pkg::CSC_RESP_OKAY;

  // Far side and device under test
  csc_batt_model batt (.SYS_CLK(clk), .settled(st), .undervolt(uv), .in_reg(rg), .warm(wm),
    .not_hot(nh), .timeout(tmo), .slope(slp));
  csc_charge_state_controller csc_charge_state_controller_inst (.SYS_CLK(clk), .SRST(srst),
    .SUPPLY_SETTLED(st), .CELL_UNDERVOLT(uv), .IN_REGULATION(rg), .WARM_ENOUGH(wm),
    .NOT_OVERHEATED(nh), .CHARGE_TIMEOUT(tmo), .SLOPE_DETECT(slp), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .FAST_CHARGE(fast), .IRQ(irq));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%08h exp=%08h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
    chk({30'h0, br}, {30'h0, exp_resp});
    @(posedge clk);
  endtask

  // AXI4-Lite read, data taken at the response edge
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    chk({30'h0, rr}, {30'h0, exp_resp});
    rry <= 1'b0;
    @(posedge clk);
  endtask

  // Supply-settle cycle with the given conditions
  task automatic restart(input logic u, input logic r, input logic w, input logic h);
    batt.set_env(1'b0, u, r, w, h);
    tick(3);
    chk({31'h0, fast}, 32'h0);
    batt.set_env(1'b1, u, r, w, h);
    tick(3);
  endtask

  task automatic t_regs();
    // Unmapped offsets answer with an error and change nothing
    exp_resp = csc_pkg::CSC_RESP_SLVERR;
    axi_wr(4'h5, 32'h1F);
    axi_rd(4'h1, v);
    chk(v, 32'h0);
    exp_resp = csc_pkg::CSC_RESP_OKAY;
    axi_rd(csc_pkg::CSC_OFS_MASK, v);
    chk(v, 32'h0);
    axi_rd(csc_pkg::CSC_OFS_CONTROL, v);
    chk(v, 32'h1);
    axi_wr(csc_pkg::CSC_OFS_CONTROL, 32'h0);
    restart(1'b0, 1'b0, 1'b1, 1'b1);
    chk({31'h0, fast}, 32'h0);
    axi_wr(csc_pkg::CSC_OFS_CONTROL, 32'h1);
  endtask

  task automatic t_terminate();
    restart(1'b0, 1'b0, 1'b1, 1'b1);
    chk({31'h0, fast}, 32'h1);
    tick(10);
    chk({31'h0, fast}, 32'h1);
    axi_rd(csc_pkg::CSC_OFS_STATUS, v);
    axi_wr(csc_pkg::CSC_OFS_MASK, 32'h0C);
    batt.fire(1'b1, 1'b0);
    tick(3);
    chk({30'h0, fast, irq}, 32'h1);
    axi_rd(csc_pkg::CSC_OFS_STATUS, v);
    chk(v, 32'h06);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    restart(1'b0, 1'b0, 1'b1, 1'b1);
    batt.fire(1'b0, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h0);
    axi_wr(csc_pkg::CSC_OFS_MASK, 32'h0);
  endtask

  task automatic t_insert();
    restart(1'b0, 1'b1, 1'b1, 1'b1);
    chk({31'h0, fast}, 32'h0);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h1);
    batt.set_env(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h0);
  endtask

  task automatic t_undervolt();
    restart(1'b1, 1'b0, 1'b1, 1'b1);
    chk({31'h0, fast}, 32'h0);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h1);
    batt.set_env(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h0);
  endtask

  task automatic t_cold();
    restart(1'b0, 1'b0, 1'b0, 1'b1);
    chk({31'h0, fast}, 32'h0);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h1);
    batt.fire(1'b1, 1'b0);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    tick(3);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h0);
  endtask

  task automatic t_hot();
    restart(1'b0, 1'b0, 1'b1, 1'b0);
    chk({31'h0, fast}, 32'h0);
    axi_rd(csc_pkg::CSC_OFS_STATE, v);
    chk(v, 32'h2);
    batt.set_env(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    tick(3);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h0);
    restart(1'b0, 1'b0, 1'b1, 1'b1);
    chk({31'h0, fast}, 32'h1);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    tick(3);
    chk({31'h0, fast}, 32'h0);
    batt.set_env(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    tick(3);
    batt.set_env(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    tick(3);
    chk({31'h0, fast}, 32'h0);
  endtask

  // Watchdog
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end

  // Reset, then the scenarios
  initial begin
    srst = 1'b1;
    awa = 4'h0;
    ara = 4'h0;
    wd = 32'h0;
    awv = 1'b0;
    wv = 1'b0;
    bry = 1'b0;
    arv = 1'b0;
    rry = 1'b0;
    tick(12);
    chk({31'h0, fast}, 32'h0);
    srst <= 1'b0;
    tick(1);
    t_regs();
    t_terminate();
    t_insert();
    t_undervolt();
    t_cold();
    t_hot();
    give_verdict();
  end
endmodule
